/* design/parallel_program_port_pkg.sv */
package parallel_program_port_pkg;

  // Action select codes sampled on the latch pulse.
  localparam logic [1:0] ACTION_ADDRESS = 2'h0;
  localparam logic [1:0] ACTION_DATA    = 2'h1;
  localparam logic [1:0] ACTION_COMMAND = 2'h2;

  // Command byte bit positions.
  localparam int CMD_CHIP_ERASE  = 7;
  localparam int CMD_WRITE_FUSES = 6;
  localparam int CMD_WRITE_LOCKS = 5;
  localparam int CMD_WRITE_MEM   = 4;
  localparam int CMD_READ_SIG    = 3;
  localparam int CMD_READ_LOCKS  = 2;
  localparam int CMD_READ_MEM    = 1;
  localparam int CMD_TARGET_EE   = 0;

  // Data bit positions for fuse and lock writes.
  localparam int WR_FUSE_SERIAL  = 5;
  localparam int WR_FUSE_STARTUP = 0;
  localparam int WR_LOCK_ONE     = 1;
  localparam int WR_LOCK_TWO     = 0;

  // Data bit positions for the lock and fuse status read.
  localparam int RD_LOCK_ONE     = 7;
  localparam int RD_LOCK_TWO     = 6;
  localparam int RD_FUSE_SERIAL  = 5;
  localparam int RD_FUSE_STARTUP = 0;

  // Only the low bits of the high address byte reach the flash.
  localparam int FLASH_HIGH_BITS = 3;
  localparam int ADDR_WIDTH      = 11;

  // Reset values: zero means programmed.
  localparam logic [7:0] RESET_BYTE          = 8'h00;
  localparam logic       LOCK_RESET          = 1'b1;
  localparam logic       FUSE_SERIAL_RESET   = 1'b0;
  localparam logic       FUSE_STARTUP_RESET  = 1'b1;

  // Signature bytes; the values are arbitrary.
  localparam logic [7:0] SIGNATURE_0 = 8'h5A;
  localparam logic [7:0] SIGNATURE_1 = 8'hA5;
  localparam logic [7:0] SIGNATURE_2 = 8'h3C;

  // Write FIFO geometry: eeprom flag, address, high byte flag, data.
  localparam int WRITE_WORD_WIDTH = 1 + ADDR_WIDTH + 1 + 8;
  localparam int WRITE_FIFO_DEPTH = 8;

endpackage

/* design/strobe_edge.sv */
`timescale 1ns/10ps

module strobe_edge
(
  input  wire logic core_clk,
  input  wire logic reset_n,
  input  wire logic level_in,
  input  wire logic idle_level,
  output logic      rise,
  output logic      fall
);

  typedef struct packed {
    logic primed;
    logic prev;
    logic rise;
    logic fall;
  } edge_state_t;

  edge_state_t state;
  edge_state_t next_state;
  logic        last_level;

  // Until the first sample is taken the pin is taken to rest at its idle level.
  // This keeps the release of reset from showing a false edge.
  always_comb
  begin
    last_level        = state.primed ? state.prev : idle_level;
    next_state        = state;
    next_state.primed = 1'b1;
    next_state.prev   = level_in;
    next_state.rise   = level_in & ~last_level;
    next_state.fall   = ~level_in & last_level;
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      state <= '0;
    else
    begin
      state <= next_state;
    end
  end

  assign rise = state.rise;
  assign fall = state.fall;

endmodule // strobe_edge

/* design/write_fifo.sv */
`timescale 1ns/10ps

module write_fifo
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
)
(
  input  wire logic             core_clk,
  input  wire logic             reset_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);

  localparam int PW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0]               rd_ptr;
    logic [PW-1:0]               wr_ptr;
    logic [PW:0]                 count;
  } fifo_state_t;

  fifo_state_t state;
  fifo_state_t next_state;
  logic        push;
  logic        pop;

  assign in_ready  = state.count != (PW+1)'(DEPTH);
  assign out_valid = state.count != '0;
  assign out_data  = state.mem[state.rd_ptr];

  always_comb
  begin
    next_state = state;
    push       = in_valid & in_ready;
    pop        = out_valid & out_ready;
    if (push)
    begin
      next_state.mem[state.wr_ptr] = in_data;
      next_state.wr_ptr = (state.wr_ptr == PW'(DEPTH-1)) ? '0 : state.wr_ptr + 1'b1;
    end
    if (pop)
    begin
      next_state.rd_ptr = (state.rd_ptr == PW'(DEPTH-1)) ? '0 : state.rd_ptr + 1'b1;
    end
    if (push && !pop)
      next_state.count = state.count + 1'b1;
    else if (pop && !push)
      next_state.count = state.count - 1'b1;
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      state <= '0;
    else
    begin
      state <= next_state;
    end
  end

endmodule // write_fifo

/* design/parallel_program_port.sv */
`timescale 1ns/10ps

module parallel_program_port
(
  input  wire logic                                               core_clk,
  input  wire logic                                               reset_n,
  input  wire logic                                               prog_enable,
  input  wire logic                                               latch_pulse_pin,
  input  wire logic                                               action_sel_bit1,
  input  wire logic                                               action_sel_bit0,
  input  wire logic                                               byte_select,
  input  wire logic                                               output_enable_n,
  input  wire logic                                               write_strobe_n,
  input  wire logic [7:0]                                         prog_data_in,
  output logic      [7:0]                                         prog_data_out,
  output logic                                                    prog_data_oe_n,
  output logic                                                    ready_busy_n,
  output logic      [parallel_program_port_pkg::ADDR_WIDTH-1:0]   nv_rd_addr,
  output logic                                                    nv_rd_eeprom,
  input  wire logic [15:0]                                        nv_rd_data,
  output logic                                                    nv_wr_valid,
  input  wire logic                                               nv_wr_ready,
  output logic                                                    nv_wr_eeprom,
  output logic      [parallel_program_port_pkg::ADDR_WIDTH-1:0]   nv_wr_addr,
  output logic                                                    nv_wr_high,
  output logic      [7:0]                                         nv_wr_data,
  input  wire logic                                               nv_wr_busy,
  output logic                                                    nv_erase_req,
  input  wire logic                                               nv_erase_done,
  output logic                                                    lock_bit_one,
  output logic                                                    lock_bit_two,
  output logic                                                    serial_download_fuse,
  output logic                                                    short_startup_fuse
);

  localparam int AW = parallel_program_port_pkg::ADDR_WIDTH;
  localparam int WW = parallel_program_port_pkg::WRITE_WORD_WIDTH;

  typedef enum logic [0:0] {ERASE_IDLE, ERASE_RUN} erase_state_t;

  typedef struct packed {
    logic [7:0]   command;
    logic [7:0]   addr_low;
    logic [7:0]   addr_high;
    logic [7:0]   data;
    logic         lock_one;
    logic         lock_two;
    logic         fuse_serial;
    logic         fuse_startup;
    erase_state_t erase;
    logic         lock_erase_armed;
    logic         stage_valid;
    logic [WW-1:0] stage_word;
    logic [7:0]   dout;
    logic         doe_n;
    logic         ready;
    logic [AW-1:0] rd_addr;
    logic         rd_eeprom;
  } port_state_t;

  port_state_t   state;
  port_state_t   next_state;
  logic          latch_rise;
  logic          write_fall;
  logic          fifo_in_valid;
  logic          fifo_in_ready;
  logic [WW-1:0] fifo_in_word;
  logic          fifo_out_valid;
  logic          fifo_out_ready;
  logic [WW-1:0] fifo_out_word;
  logic [1:0]    action;
  logic [AW-1:0] cur_addr;
  logic [7:0]    read_byte;
  logic          read_cmd;

  // Both strobes are seen through edge detectors; each event lasts one clock.
  strobe_edge latch_edge
  (
    .core_clk   (core_clk),
    .reset_n    (reset_n),
    .level_in   (latch_pulse_pin),
    .idle_level (1'b0),
    .rise       (latch_rise),
    .fall       ()
  );

  strobe_edge write_edge
  (
    .core_clk   (core_clk),
    .reset_n    (reset_n),
    .level_in   (write_strobe_n),
    .idle_level (1'b1),
    .rise       (),
    .fall       (write_fall)
  );

  // Writes queue here so that strobes are not lost while the array is programming.
  write_fifo
  #(
    .WIDTH (WW),
    .DEPTH (parallel_program_port_pkg::WRITE_FIFO_DEPTH)
  )
  write_queue
  (
    .core_clk  (core_clk),
    .reset_n   (reset_n),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (fifo_in_word),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out_word)
  );

  assign action   = {action_sel_bit1, action_sel_bit0};
  // Only three bits of the high byte reach the flash, giving an eleven bit word address.
  assign cur_addr = {state.addr_high[parallel_program_port_pkg::FLASH_HIGH_BITS-1:0],
                     state.addr_low};
  // Any of the three read commands lets output enable drive the bus.
  assign read_cmd = state.command[parallel_program_port_pkg::CMD_READ_MEM] |
                    state.command[parallel_program_port_pkg::CMD_READ_LOCKS] |
                    state.command[parallel_program_port_pkg::CMD_READ_SIG];

  // A memory write is queued on the strobe edge; byte_select names the half.
  assign fifo_in_valid = prog_enable & write_fall &
                         state.command[parallel_program_port_pkg::CMD_WRITE_MEM];
  assign fifo_in_word  = {state.command[parallel_program_port_pkg::CMD_TARGET_EE],
                          cur_addr, byte_select, state.data};
  assign fifo_out_ready = ~state.stage_valid | nv_wr_ready;

  // Read data mux for the three read commands.
  always_comb
  begin
    read_byte = parallel_program_port_pkg::RESET_BYTE;
    if (state.command[parallel_program_port_pkg::CMD_READ_MEM])
    begin
      if (state.command[parallel_program_port_pkg::CMD_TARGET_EE] || !byte_select)
        read_byte = nv_rd_data[7:0];
      else
        read_byte = nv_rd_data[15:8];
    end
    else if (state.command[parallel_program_port_pkg::CMD_READ_LOCKS])
    begin
      read_byte[parallel_program_port_pkg::RD_LOCK_ONE]     = state.lock_one;
      read_byte[parallel_program_port_pkg::RD_LOCK_TWO]     = state.lock_two;
      read_byte[parallel_program_port_pkg::RD_FUSE_SERIAL]  = state.fuse_serial;
      read_byte[parallel_program_port_pkg::RD_FUSE_STARTUP] = state.fuse_startup;
    end
    else if (state.command[parallel_program_port_pkg::CMD_READ_SIG])
    begin
      unique case (state.addr_low)
        8'h00:   read_byte = parallel_program_port_pkg::SIGNATURE_0;
        8'h01:   read_byte = parallel_program_port_pkg::SIGNATURE_1;
        8'h02:   read_byte = parallel_program_port_pkg::SIGNATURE_2;
        default: read_byte = parallel_program_port_pkg::RESET_BYTE;
      endcase
    end
  end

  always_comb
  begin
    next_state = state;

    // Registers load only on a latch edge, per the sampled action code.
    if (prog_enable && latch_rise)
    begin
      unique case (action)
        parallel_program_port_pkg::ACTION_ADDRESS:
          if (byte_select)
            next_state.addr_high = prog_data_in;
          else
            next_state.addr_low = prog_data_in;
        parallel_program_port_pkg::ACTION_DATA:
          next_state.data = prog_data_in;
        parallel_program_port_pkg::ACTION_COMMAND:
        begin
          next_state.command = prog_data_in;
          if (prog_data_in[parallel_program_port_pkg::CMD_CHIP_ERASE])
          begin
            next_state.erase            = ERASE_RUN;
            next_state.lock_erase_armed = 1'b0;
          end
        end
        default:
          next_state.command = state.command;
      endcase
    end

    if (prog_enable && write_fall)
    begin
      if (state.command[parallel_program_port_pkg::CMD_CHIP_ERASE] && state.erase == ERASE_RUN)
        next_state.lock_erase_armed = 1'b1;
      if (state.command[parallel_program_port_pkg::CMD_WRITE_FUSES])
      begin
        next_state.fuse_serial  = state.data[parallel_program_port_pkg::WR_FUSE_SERIAL];
        next_state.fuse_startup = state.data[parallel_program_port_pkg::WR_FUSE_STARTUP];
      end
      if (state.command[parallel_program_port_pkg::CMD_WRITE_LOCKS])
      begin
        // Lock bits can only be programmed here; a chip erase or reset_n brings them back.
        next_state.lock_one = state.lock_one &
                              state.data[parallel_program_port_pkg::WR_LOCK_ONE];
        next_state.lock_two = state.lock_two &
                              state.data[parallel_program_port_pkg::WR_LOCK_TWO];
      end
    end

    // Locks are released only once the arrays report the erase complete.
    if (state.erase == ERASE_RUN && nv_erase_done)
    begin
      next_state.erase = ERASE_IDLE;
      if (state.lock_erase_armed || (prog_enable && write_fall &&
          state.command[parallel_program_port_pkg::CMD_CHIP_ERASE]))
      begin
        next_state.lock_one = parallel_program_port_pkg::LOCK_RESET;
        next_state.lock_two = parallel_program_port_pkg::LOCK_RESET;
      end
      next_state.lock_erase_armed = 1'b0;
    end

    // Output stage holding the word offered to the array.
    if (fifo_out_ready)
    begin
      next_state.stage_valid = fifo_out_valid;
      next_state.stage_word  = fifo_out_word;
    end

    // Busy covers queued, offered and in-flight writes; erase does not count.
    next_state.ready = ~(fifo_in_valid | fifo_out_valid | state.stage_valid | nv_wr_busy |
                         ~fifo_in_ready);

    // The array address follows the latched bytes one clock later.
    next_state.rd_addr   = cur_addr;
    next_state.rd_eeprom = state.command[parallel_program_port_pkg::CMD_TARGET_EE];

    // Bus is driven only for a read with output enable low.
    next_state.doe_n = ~(prog_enable & ~output_enable_n & read_cmd);
    next_state.dout  = read_byte;
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      // Locks come up unprogrammed and the fuses at their default states.
      state              <= '0;
      state.erase        <= ERASE_IDLE;
      state.lock_one     <= parallel_program_port_pkg::LOCK_RESET;
      state.lock_two     <= parallel_program_port_pkg::LOCK_RESET;
      state.fuse_serial  <= parallel_program_port_pkg::FUSE_SERIAL_RESET;
      state.fuse_startup <= parallel_program_port_pkg::FUSE_STARTUP_RESET;
      state.doe_n        <= 1'b1;
      state.ready        <= 1'b1;
    end
    else
    begin
      state <= next_state;
    end
  end

  assign prog_data_out        = state.dout;
  assign prog_data_oe_n       = state.doe_n;
  assign ready_busy_n         = state.ready;
  assign nv_rd_addr           = state.rd_addr;
  assign nv_rd_eeprom         = state.rd_eeprom;
  assign nv_wr_valid          = state.stage_valid;
  assign nv_wr_eeprom         = state.stage_word[WW-1];
  assign nv_wr_addr           = state.stage_word[WW-2 -: AW];
  assign nv_wr_high           = state.stage_word[8];
  assign nv_wr_data           = state.stage_word[7:0];
  assign nv_erase_req         = state.erase == ERASE_RUN;
  assign lock_bit_one         = state.lock_one;
  assign lock_bit_two         = state.lock_two;
  assign serial_download_fuse = state.fuse_serial;
  assign short_startup_fuse   = state.fuse_startup;

endmodule // parallel_program_port

/* tb/parallel_program_port_properties.sv */
`timescale 1ns/10ps

module parallel_program_port_properties
(
  input wire logic                                             core_clk,
  input wire logic                                             reset_n,
  input wire logic                                             prog_enable,
  input wire logic                                             latch_pulse_pin,
  input wire logic                                             output_enable_n,
  input wire logic                                             write_strobe_n,
  input wire logic                                             prog_data_oe_n,
  input wire logic                                             ready_busy_n,
  input wire logic [parallel_program_port_pkg::ADDR_WIDTH-1:0] nv_rd_addr,
  input wire logic                                             nv_wr_valid,
  input wire logic                                             nv_wr_ready,
  input wire logic [7:0]                                       nv_wr_data,
  input wire logic                                             nv_wr_busy,
  input wire logic                                             nv_erase_req,
  input wire logic                                             nv_erase_done,
  input wire logic                                             lock_bit_one,
  input wire logic                                             serial_download_fuse,
  input wire logic                                             short_startup_fuse
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);

  a_bus_only_read: assert property
    (!prog_data_oe_n |-> $past(!output_enable_n && prog_enable))
    else $error("data bus driven outside a read");
  a_busy_while_queued: assert property (nv_wr_valid |-> !ready_busy_n)
    else $error("ready shown while a write is queued");
  a_ready_after_array: assert property ($rose(ready_busy_n) |-> !$past(nv_wr_busy))
    else $error("ready returned while the array is busy");
  a_busy_from_strobe: assert property ($fell(ready_busy_n) |->
    !$past(write_strobe_n, 2) || !$past(write_strobe_n, 3))
    else $error("busy without a write strobe");
  a_word_held: assert property
    (nv_wr_valid && !nv_wr_ready |=> nv_wr_valid && $stable(nv_wr_data))
    else $error("write word changed before it was taken");
  a_erase_keeps_ready: assert property
    ($rose(nv_erase_req) && ready_busy_n |=> ready_busy_n [*4])
    else $error("chip erase moved ready_busy_n");
  a_lock_release_erase: assert property ($rose(lock_bit_one) |->
    $past(nv_erase_done) || $past(nv_erase_done, 2))
    else $error("lock released without erase completion");
  a_fuse_kept_erase: assert property (nv_erase_req |=>
    $stable(serial_download_fuse) && $stable(short_startup_fuse))
    else $error("fuse changed during chip erase");
  a_addr_from_latch: assert property
    ($changed(nv_rd_addr) |-> $past(latch_pulse_pin, 3))
    else $error("address changed without a latch pulse");

  c_write_taken: cover property (nv_wr_valid && nv_wr_ready);
  c_erase_done: cover property (nv_erase_done);
  c_read_drive: cover property (!prog_data_oe_n);
endmodule // parallel_program_port_properties

/* tb/nv_array_model.sv */
`timescale 1ns/10ps

module nv_array_model
#(
  parameter int ERASE_CYCLES = 40,
  parameter int PROG_CYCLES  = 6
)
(
  input  wire logic        core_clk,
  input  wire logic        reset_n,
  input  wire logic        hold,
  input  wire logic [10:0] nv_rd_addr,
  input  wire logic        nv_rd_eeprom,
  output logic      [15:0] nv_rd_data,
  input  wire logic        nv_wr_valid,
  output logic             nv_wr_ready,
  input  wire logic        nv_wr_eeprom,
  input  wire logic [10:0] nv_wr_addr,
  input  wire logic        nv_wr_high,
  input  wire logic [7:0]  nv_wr_data,
  output logic             nv_wr_busy,
  input  wire logic        nv_erase_req,
  output logic             nv_erase_done
);
  logic [15:0] flash [2048];
  logic [7:0]  ee [256];
  int          busy_cnt;
  int          erase_cnt;

  // Arrays start erased; hold stalls the write handshake so the queue backs up.
  initial
  begin
    foreach (flash[i]) flash[i] = 16'hffff;
    foreach (ee[i]) ee[i] = 8'hff;
  end
  assign nv_wr_ready = !hold && busy_cnt == 0;
  assign nv_wr_busy  = busy_cnt != 0;
  assign nv_rd_data  = nv_rd_eeprom ? {8'h00, ee[nv_rd_addr[7:0]]} : flash[nv_rd_addr];

  always @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      busy_cnt <= 0;
      erase_cnt <= 0;
      nv_erase_done <= 1'b0;
    end
    else
    begin
      nv_erase_done <= 1'b0;
      if (busy_cnt != 0) busy_cnt <= busy_cnt - 1;
      if (nv_wr_valid && nv_wr_ready)
      begin
        busy_cnt <= PROG_CYCLES;
        if (nv_wr_eeprom) ee[nv_wr_addr[7:0]] <= nv_wr_data;
        else if (nv_wr_high) flash[nv_wr_addr][15:8] <= nv_wr_data;
        else flash[nv_wr_addr][7:0] <= nv_wr_data;
      end
      erase_cnt <= nv_erase_req ? erase_cnt + 1 : 0;
      if (nv_erase_req && erase_cnt == ERASE_CYCLES)
      begin
        nv_erase_done <= 1'b1;
        foreach (flash[i]) flash[i] <= 16'hffff;
        foreach (ee[i]) ee[i] <= 8'hff;
      end
    end
  end
endmodule // nv_array_model

/* tb/parallel_program_port_tb.sv */
`timescale 1ns/10ps

module parallel_program_port_tb;
  logic        core_clk = 1'b0, reset_n = 1'b0, prog_enable = 1'b0, hold = 1'b0;
  logic        latch_pulse_pin = 1'b0, action_sel_bit1 = 1'b1, action_sel_bit0 = 1'b1;
  logic        byte_select = 1'b0, output_enable_n = 1'b1, write_strobe_n = 1'b1;
  logic [7:0]  prog_data_in = 8'h00, prog_data_out, nv_wr_data;
  logic [10:0] nv_rd_addr, nv_wr_addr;
  logic [15:0] nv_rd_data;
  logic        prog_data_oe_n, ready_busy_n, nv_rd_eeprom, nv_wr_valid, nv_wr_ready;
  logic        nv_wr_eeprom, nv_wr_high, nv_wr_busy, nv_erase_req, nv_erase_done;
  logic        lock_bit_one, lock_bit_two, serial_download_fuse, short_startup_fuse;
  int          num_errors = 0, total_checks = 0;

  parallel_program_port i_parallel_program_port (.core_clk, .reset_n, .prog_enable,
    .latch_pulse_pin, .action_sel_bit1, .action_sel_bit0, .byte_select, .output_enable_n,
    .write_strobe_n, .prog_data_in, .prog_data_out, .prog_data_oe_n, .ready_busy_n,
    .nv_rd_addr, .nv_rd_eeprom, .nv_rd_data, .nv_wr_valid, .nv_wr_ready, .nv_wr_eeprom,
    .nv_wr_addr, .nv_wr_high, .nv_wr_data, .nv_wr_busy, .nv_erase_req, .nv_erase_done,
    .lock_bit_one, .lock_bit_two, .serial_download_fuse, .short_startup_fuse);
  nv_array_model i_nv_array_model (.core_clk, .reset_n, .hold, .nv_rd_addr, .nv_rd_eeprom,
    .nv_rd_data, .nv_wr_valid, .nv_wr_ready, .nv_wr_eeprom, .nv_wr_addr, .nv_wr_high,
    .nv_wr_data, .nv_wr_busy, .nv_erase_req, .nv_erase_done);

  always #2.5 core_clk = ~core_clk;

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  // Outputs are judged at the falling edge, where every update has settled.
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    @(negedge core_clk);
    total_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("FAIL at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run;
    $display("checks %0d, mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic latch(input logic [1:0] act, input logic bs, input logic [7:0] d);
    cyc(1);
    {action_sel_bit1, action_sel_bit0} <= act;
    byte_select <= bs;
    prog_data_in <= d;
    cyc(1);
    latch_pulse_pin <= 1'b1;
    cyc(2);
    latch_pulse_pin <= 1'b0;
    cyc(2);
  endtask

  task automatic wr(input logic bs);
    cyc(1);
    byte_select <= bs;
    write_strobe_n <= 1'b0;
    cyc(4);
    write_strobe_n <= 1'b1;
    cyc(2);
  endtask

  task automatic wait_ready;
    for (int i = 0; i < 300 && ready_busy_n !== 1'b1; i++) cyc(1);
    check(16'(ready_busy_n), 16'h0001);
  endtask

  task automatic rd(input logic bs, input logic [7:0] exp);
    cyc(1);
    byte_select <= bs;
    output_enable_n <= 1'b0;
    cyc(3);
    check(16'(prog_data_oe_n), 16'h0000);
    check(16'(prog_data_out), 16'(exp));
    cyc(1);
    output_enable_n <= 1'b1;
    cyc(2);
    check(16'(prog_data_oe_n), 16'h0001);
  endtask

  task automatic erase;
    latch(2'h2, 1'b0, 8'h80);
    wr(1'b0);
    check(16'(ready_busy_n), 16'h0001);
    cyc(60);
  endtask

  task automatic t_reset;
    check(16'(ready_busy_n), 16'h0001);
    check(16'(prog_data_oe_n), 16'h0001);
    check(16'({lock_bit_one, lock_bit_two, serial_download_fuse, short_startup_fuse}),
      16'h000d);
  endtask

  task automatic t_locks;
    erase;
    latch(2'h2, 1'b0, 8'h20);
    latch(2'h1, 1'b0, 8'h01);
    wr(1'b0);
    check(16'({lock_bit_one, lock_bit_two}), 16'h0001);
    latch(2'h1, 1'b0, 8'h00);
    wr(1'b0);
    check(16'({lock_bit_one, lock_bit_two}), 16'h0000);
    latch(2'h2, 1'b0, 8'h80);
    wr(1'b0);
    check(16'(lock_bit_one), 16'h0000);
    cyc(60);
    check(16'({lock_bit_one, lock_bit_two, serial_download_fuse, short_startup_fuse}),
      16'h000d);
  endtask

  task automatic t_fuses;
    latch(2'h2, 1'b0, 8'h40);
    latch(2'h1, 1'b0, 8'h20);
    wr(1'b0);
    check(16'({serial_download_fuse, short_startup_fuse}), 16'h0002);
    latch(2'h2, 1'b0, 8'h04);
    rd(1'b1, 8'he0);
  endtask

  task automatic t_flash;
    latch(2'h2, 1'b0, 8'h10);
    latch(2'h0, 1'b0, 8'h34);
    latch(2'h0, 1'b1, 8'h0d);
    latch(2'h1, 1'b0, 8'ha7);
    wr(1'b0);
    check(16'(ready_busy_n), 16'h0000);
    wait_ready;
    latch(2'h1, 1'b0, 8'h5c);
    wr(1'b1);
    wait_ready;
    check(16'(nv_rd_addr), 16'h0534);
    latch(2'h2, 1'b0, 8'h02);
    rd(1'b0, 8'ha7);
    rd(1'b1, 8'h5c);
    latch(2'h0, 1'b0, 8'h35);
    rd(1'b0, 8'hff);
  endtask

  task automatic t_eeprom;
    latch(2'h2, 1'b0, 8'h11);
    latch(2'h0, 1'b0, 8'h3f);
    latch(2'h1, 1'b0, 8'h99);
    wr(1'b0);
    wait_ready;
    latch(2'h2, 1'b0, 8'h03);
    rd(1'b0, 8'h99);
    latch(2'h2, 1'b0, 8'h02);
    rd(1'b0, 8'hff);
  endtask

  // With the array stalled, the first word waits in the output stage, the next eight fill the queue, and the tenth is dropped.
  task automatic t_fifo;
    cyc(1);
    hold <= 1'b1;
    latch(2'h2, 1'b0, 8'h10);
    latch(2'h0, 1'b1, 8'h00);
    for (int i = 0; i < 10; i++)
    begin
      latch(2'h0, 1'b0, 8'(i));
      latch(2'h1, 1'b0, 8'(8'h40 + i));
      wr(1'b0);
      check(16'(ready_busy_n), 16'h0000);
    end
    cyc(1);
    hold <= 1'b0;
    wait_ready;
    latch(2'h2, 1'b0, 8'h02);
    for (int i = 0; i < 10; i++)
    begin
      latch(2'h0, 1'b0, 8'(i));
      rd(1'b0, i < 9 ? 8'(8'h40 + i) : 8'hff);
    end
  endtask

  task automatic t_misc;
    latch(2'h2, 1'b0, 8'h08);
    for (int i = 0; i < 3; i++)
    begin
      latch(2'h0, 1'b0, 8'(i));
      rd(1'b0, i == 0 ? parallel_program_port_pkg::SIGNATURE_0 :
        i == 1 ? parallel_program_port_pkg::SIGNATURE_1 : parallel_program_port_pkg::SIGNATURE_2);
    end
    latch(2'h0, 1'b0, 8'h77);
    latch(2'h3, 1'b0, 8'h12);
    prog_enable <= 1'b0;
    latch(2'h0, 1'b0, 8'h55);
    prog_enable <= 1'b1;
    check(16'(nv_rd_addr[7:0]), 16'h0077);
    latch(2'h2, 1'b0, 8'h10);
    output_enable_n <= 1'b0;
    cyc(3);
    check(16'(prog_data_oe_n), 16'h0001);
    cyc(1);
    output_enable_n <= 1'b1;
  endtask

  initial
  begin
    cyc(8);
    reset_n <= 1'b1;
    cyc(2);
    prog_enable <= 1'b1;
    cyc(2);
    t_reset;
    t_locks;
    t_fuses;
    t_flash;
    t_eeprom;
    t_fifo;
    t_misc;
    complete_run;
  end

  initial
  begin
    #200000;
    num_errors++;
    complete_run;
  end
endmodule // parallel_program_port_tb

bind parallel_program_port parallel_program_port_properties i_parallel_program_port_properties (
  .core_clk, .reset_n, .prog_enable, .latch_pulse_pin, .output_enable_n, .write_strobe_n,
  .prog_data_oe_n, .ready_busy_n, .nv_rd_addr, .nv_wr_valid, .nv_wr_ready, .nv_wr_data,
  .nv_wr_busy, .nv_erase_req, .nv_erase_done, .lock_bit_one, .serial_download_fuse,
  .short_startup_fuse);
